// ==== include/qec_pkg.sv ====
// Constants and types shared by the quadrature encoder counter
package qec_pkg;

  localparam int          QEC_CNT_W      = 32;
  localparam logic [31:0] QEC_CNT_RST    = 32'h0000_0000;
  localparam logic [31:0] QEC_MASK_NARROW = 32'h0000_ffff;
  localparam logic [31:0] QEC_MASK_WIDE  = 32'hffff_ffff;
  localparam logic [31:0] QEC_ONE        = 32'h0000_0001;
  localparam int          QEC_HI_LSB     = 16;
  localparam logic [15:0] QEC_HI_ZERO    = 16'h0000;

  // Track rate limit against the 40 MHz core clock
  localparam int QEC_CLK_HZ      = 40_000_000;
  localparam int QEC_TRK_FMAX_HZ = 1_000_000;
  localparam int QEC_EDGES_PER_P = 4;
  localparam int QEC_EDGE_GAP_CYC = QEC_CLK_HZ / (QEC_TRK_FMAX_HZ * QEC_EDGES_PER_P);

  typedef enum logic [1:0] {
    QEC_EVAL_X4,
    QEC_EVAL_X2,
    QEC_EVAL_X1,
    QEC_EVAL_PULSE
  } qec_eval_t;

  typedef enum logic [1:0] {
    QEC_STEP_NONE,
    QEC_STEP_UP,
    QEC_STEP_DN
  } qec_step_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } qec_trk_t;

endpackage : qec_pkg

// ==== logic/qec_trk_in.sv ====
// Track receiver: forms track levels from true and inverted lines
`timescale 1ns/1ps
module qec_trk_in
  import qec_pkg::*;
(
  input  wire logic     mclk_i,
  input  wire logic     rstn_i,
  input  wire qec_trk_t trk_p_i,
  input  wire qec_trk_t trk_n_i,
  input  wire logic     diff_en_i,
  output qec_trk_t      trk_o,
  output qec_trk_t      trk_prev_o
);

  qec_trk_t trk_reg;
  qec_trk_t trk_next;
  qec_trk_t prev_reg;
  qec_trk_t pair_ok;

  // A pair with equal legs is invalid and the last level is kept
  assign pair_ok  = trk_p_i ^ trk_n_i;
  assign trk_next = diff_en_i ? ((pair_ok & trk_p_i) | (~pair_ok & trk_reg)) : trk_p_i;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trk_reg  <= '0;
      prev_reg <= '0;
    end else begin
      trk_reg  <= trk_next;
      prev_reg <= trk_reg;
    end
  end

  assign trk_o      = trk_reg;
  assign trk_prev_o = prev_reg;

endmodule : qec_trk_in

// ==== logic/qec_top.sv ====
// Quadrature decoder, position counter and latches
`timescale 1ns/1ps
// Overview of operation
// - Count up when A leads B by 90 degrees, down when it lags.
// - Four-fold mode counts every edge of tracks A and B, except when A and B change in the same sample.
// - Evaluation factor selectable: four-fold, two-fold, single, or pulse.
// - Counter and zero latch are 16 bits, or 32 bits when wide mode selected.
// - Rising track C captures the counter into the zero latch.
// - Pulse mode counts rising A edges, direction taken from B level.
// - Edges up to 1 MHz track rate, 4 M counts per second, all counted.
// - Auxiliary inputs latch, clear or preset the counter on their rising edge.
// - Differential mode forms each track from its complementary pair.
module qec_top
  import qec_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire qec_trk_t    trk_p_i,
  input  wire qec_trk_t    trk_n_i,
  input  wire logic        diff_en_i,
  input  wire qec_eval_t   eval_mode_i,
  input  wire logic        wide_en_i,
  input  wire logic        zlatch_en_i,
  input  wire logic        aux_latch_i,
  input  wire logic        aux_clear_i,
  input  wire logic        aux_set_i,
  input  wire logic [31:0] preset_i,
  output logic      [31:0] count_o,
  output logic             dir_o,
  output logic      [31:0] zlatch_o,
  output logic             zlatch_stb_o,
  output logic      [31:0] aux_latch_o,
  output logic             aux_latch_stb_o
);

  qec_trk_t    trk_cur;
  qec_trk_t    trk_prev;
  qec_step_t   step_w;
  logic [31:0] mask_w;
  logic [31:0] stepped_w;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic        dir_reg;
  logic [31:0] zlatch_reg;
  logic        zlatch_stb_reg;
  logic [31:0] aux_latch_reg;
  logic        aux_latch_stb_reg;
  logic        aux_latch_d_reg;
  logic        aux_clear_d_reg;
  logic        aux_set_d_reg;
  logic        latch_rise_w;
  logic        clear_rise_w;
  logic        set_rise_w;
  logic        c_rise_w;

  qec_trk_in i_qec_trk_in (
    .mclk_i     (mclk_i),
    .rstn_i     (rstn_i),
    .trk_p_i    (trk_p_i),
    .trk_n_i    (trk_n_i),
    .diff_en_i  (diff_en_i),
    .trk_o      (trk_cur),
    .trk_prev_o (trk_prev)
  );

  // Decodes one sample pair into a count step for the selected evaluation
  function automatic qec_step_t step_of(input qec_trk_t prv, input qec_trk_t cur, input qec_eval_t mode);
    logic ea;
    logic eb;
    qec_step_t s;
    ea = prv.a ^ cur.a;
    eb = prv.b ^ cur.b;
    s  = QEC_STEP_NONE;
    case (mode)
      QEC_EVAL_X4: begin
        if (ea && !eb) s = (cur.a != cur.b) ? QEC_STEP_UP : QEC_STEP_DN;
        else if (eb && !ea) s = (cur.a == cur.b) ? QEC_STEP_UP : QEC_STEP_DN;
      end
      QEC_EVAL_X2: begin
        if (ea) s = (cur.a != cur.b) ? QEC_STEP_UP : QEC_STEP_DN;
      end
      QEC_EVAL_X1: begin
        if (ea && !cur.b) s = cur.a ? QEC_STEP_UP : QEC_STEP_DN;
      end
      QEC_EVAL_PULSE: begin
        if (ea && cur.a) s = cur.b ? QEC_STEP_DN : QEC_STEP_UP;
      end
      default: s = QEC_STEP_NONE;
    endcase
    return s;
  endfunction : step_of

  assign step_w       = step_of(trk_prev, trk_cur, eval_mode_i);
  assign mask_w       = wide_en_i ? QEC_MASK_WIDE : QEC_MASK_NARROW;
  assign latch_rise_w = aux_latch_i & ~aux_latch_d_reg;
  assign clear_rise_w = aux_clear_i & ~aux_clear_d_reg;
  assign set_rise_w   = aux_set_i & ~aux_set_d_reg;
  assign c_rise_w     = trk_cur.c & ~trk_prev.c;

  // Plain modular add: wraps at the selected width
  assign stepped_w = (step_w == QEC_STEP_UP) ? count_reg + QEC_ONE :
                     (step_w == QEC_STEP_DN) ? count_reg - QEC_ONE : count_reg;

  // Clear outranks preset, preset outranks counting
  assign count_next = clear_rise_w ? QEC_CNT_RST :
                      set_rise_w   ? (preset_i & mask_w) : (stepped_w & mask_w);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_reg         <= QEC_CNT_RST;
      dir_reg           <= 1'b0;
      zlatch_reg        <= QEC_CNT_RST;
      zlatch_stb_reg    <= 1'b0;
      aux_latch_reg     <= QEC_CNT_RST;
      aux_latch_stb_reg <= 1'b0;
      aux_latch_d_reg   <= 1'b0;
      aux_clear_d_reg   <= 1'b0;
      aux_set_d_reg     <= 1'b0;
    end else begin
      count_reg         <= count_next;
      aux_latch_d_reg   <= aux_latch_i;
      aux_clear_d_reg   <= aux_clear_i;
      aux_set_d_reg     <= aux_set_i;
      zlatch_stb_reg    <= c_rise_w & zlatch_en_i;
      aux_latch_stb_reg <= latch_rise_w;
      if (step_w != QEC_STEP_NONE) begin
        dir_reg <= (step_w == QEC_STEP_DN);
      end
      if (c_rise_w && zlatch_en_i) begin
        zlatch_reg <= count_reg & mask_w;
      end else begin
        zlatch_reg <= zlatch_reg & mask_w;
      end
      if (latch_rise_w) begin
        aux_latch_reg <= count_reg;
      end
    end
  end

  assign count_o         = count_reg;
  assign dir_o           = dir_reg;
  assign zlatch_o        = zlatch_reg;
  assign zlatch_stb_o    = zlatch_stb_reg;
  assign aux_latch_o     = aux_latch_reg;
  assign aux_latch_stb_o = aux_latch_stb_reg;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  logic ref_w;
  assign ref_w = clear_rise_w | set_rise_w;

  up_step_count_a: assert property (
    (step_w == QEC_STEP_UP && !ref_w) |=> count_reg == (($past(count_reg) + QEC_ONE) & $past(mask_w)))
    else $error("Up step not counted by one");

  x4_every_edge_a: assert property (
    (eval_mode_i == QEC_EVAL_X4 && ((trk_cur.a ^ trk_prev.a) != (trk_cur.b ^ trk_prev.b)) && !ref_w)
    |=> count_reg != $past(count_reg))
    else $error("Four-fold edge missed");

  x1_ignores_b_a: assert property (
    (eval_mode_i == QEC_EVAL_X1 && (trk_cur.b ^ trk_prev.b) && !(trk_cur.a ^ trk_prev.a) && !ref_w)
    |=> $stable(count_reg))
    else $error("Single evaluation counted a B edge");

  narrow_width_a: assert property (
    !wide_en_i |=> (count_reg[31:QEC_HI_LSB] == QEC_HI_ZERO && zlatch_reg[31:QEC_HI_LSB] == QEC_HI_ZERO))
    else $error("Narrow mode upper half not zero");

  zero_capture_a: assert property (
    (c_rise_w && zlatch_en_i) |=> (zlatch_stb_o && zlatch_o == ($past(count_reg) & $past(mask_w))) ##1 !zlatch_stb_o)
    else $error("Zero pulse capture wrong");

  pulse_dir_a: assert property (
    (eval_mode_i == QEC_EVAL_PULSE && trk_cur.a && !trk_prev.a && !trk_cur.b && !ref_w)
    |=> (count_reg == (($past(count_reg) + QEC_ONE) & $past(mask_w))) && !dir_o)
    else $error("Pulse mode direction wrong");

  pulse_down_a: assert property (
    (eval_mode_i == QEC_EVAL_PULSE && trk_cur.a && !trk_prev.a && trk_cur.b && !ref_w)
    |=> (count_reg == (($past(count_reg) - QEC_ONE) & $past(mask_w))) && dir_o)
    else $error("Pulse mode down count wrong");

  edge_gap_a: assert property (
    (step_w != QEC_STEP_NONE && !ref_w) |=> count_reg != $past(count_reg))
    else $error("Track step lost");

  aux_clear_a: assert property (
    clear_rise_w |=> count_reg == QEC_CNT_RST)
    else $error("Auxiliary clear failed");

  aux_set_a: assert property (
    (set_rise_w && !clear_rise_w) |=> count_reg == ($past(preset_i) & $past(mask_w)))
    else $error("Auxiliary preset failed");

  aux_latch_a: assert property (
    latch_rise_w |=> (aux_latch_stb_o && aux_latch_o == $past(count_reg)))
    else $error("Auxiliary latch failed");

  diff_hold_a: assert property (
    (diff_en_i && trk_p_i.a == trk_n_i.a) |=> trk_cur.a == $past(trk_cur.a))
    else $error("Invalid differential pair changed level");

  wrap_top_a: assert property (
    (count_reg == mask_w && step_w == QEC_STEP_UP && !ref_w && $stable(wide_en_i)) |=> count_reg == QEC_CNT_RST)
    else $error("Counter did not wrap");

  x4_count_c: cover property (eval_mode_i == QEC_EVAL_X4 && step_w == QEC_STEP_DN);
  zero_latch_c: cover property (c_rise_w && zlatch_en_i);
  wrap_c: cover property (count_reg == QEC_CNT_RST && step_w == QEC_STEP_DN);
  pulse_c: cover property (eval_mode_i == QEC_EVAL_PULSE && step_w == QEC_STEP_UP);

endmodule : qec_top

// ==== testbench/qec_enc_model.sv ====
// Encoder model driving quadrature and index tracks
`timescale 1ns/1ps
module qec_enc_model
  import qec_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic step_i,
  input  wire logic dn_i,
  input  wire logic pm_i,
  input  wire logic idx_i,
  input  wire logic flt_i,
  output qec_trk_t  trk_p_o,
  output qec_trk_t  trk_n_o
);
  logic [1:0] ph_reg = 2'h0;
  always_ff @(posedge mclk_i) begin
    if (step_i) ph_reg <= (dn_i && !pm_i) ? ph_reg - 2'h1 : ph_reg + 2'h1;
  end
  // Forward order 00,10,11,01; pulse mode puts direction on B
  assign trk_p_o = pm_i ? {ph_reg[0], dn_i, idx_i} : {^ph_reg, ph_reg[1], idx_i};
  // Line fault copies the true lines onto the inverted ones
  assign trk_n_o = flt_i ? trk_p_o : ~trk_p_o;
endmodule : qec_enc_model

// ==== testbench/tb_qec_top.sv ====
// Testbench for the quadrature encoder counter
`timescale 1ns/1ps
module tb_qec_top;
  import qec_pkg::*;
  logic        mclk_i, rstn_i, step, dn, pm, idx, flt, diff_en, wide_en, zl_en;
  logic        a_lat, a_clr, a_set, zl_stb, al_stb, dir;
  qec_eval_t   mode;
  qec_trk_t    trk_p, trk_n;
  logic [31:0] preset, count, zl, al;
  int          err_count = 0;
  int          cmp_count = 0;
  int          n;

  qec_enc_model i_qec_enc_model (.mclk_i(mclk_i), .step_i(step), .dn_i(dn), .pm_i(pm), .idx_i(idx), .flt_i(flt),
    .trk_p_o(trk_p), .trk_n_o(trk_n));
  qec_top i_qec_top (.mclk_i(mclk_i), .rstn_i(rstn_i), .trk_p_i(trk_p), .trk_n_i(trk_n),
    .diff_en_i(diff_en), .eval_mode_i(mode), .wide_en_i(wide_en), .zlatch_en_i(zl_en),
    .aux_latch_i(a_lat), .aux_clear_i(a_clr), .aux_set_i(a_set), .preset_i(preset),
    .count_o(count), .dir_o(dir), .zlatch_o(zl), .zlatch_stb_o(zl_stb),
    .aux_latch_o(al), .aux_latch_stb_o(al_stb));

  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Track steps spaced at the 4 MHz edge limit, 2 MHz in pulse mode; pulse mode toggles A every step
  task automatic steps(input int cnt, input logic d);
    dn = d;
    repeat (cnt) begin
      step = 1'b1;
      @(negedge mclk_i) step = 1'b0;
      repeat (pm ? 2 * QEC_EDGE_GAP_CYC - 1 : QEC_EDGE_GAP_CYC - 1) @(negedge mclk_i);
    end
  endtask : steps

  // Raise one input (0 index, 1 set, 2 clear, 3 latch), held high; count strobes
  task automatic hit(input int k, output int hits);
    hits = 0;
    {a_lat, a_clr, a_set, idx} = 4'h1 << k;
    repeat (6) begin
      @(posedge mclk_i) #1;
      hits += int'(zl_stb === 1'b1) + int'(al_stb === 1'b1);
    end
    @(negedge mclk_i) {a_lat, a_clr, a_set, idx} = 4'h0;
    repeat (2) @(negedge mclk_i);
  endtask : hit

  task automatic t_quad();
    diff_en = 1'b1;
    hit(2, n);
    steps(4, 1'b0);
    chk("count up", 32'h0000_0004, count);
    chk("dir up", 32'h0000_0000, {31'h0000_0000, dir});
    steps(5, 1'b1);
    chk("count wrap", 32'h0000_ffff, count);
    chk("dir down", 32'h0000_0001, {31'h0000_0000, dir});
    steps(1, 1'b0);
    $display("test quad done");
  endtask : t_quad

  // Equal legs freeze the tracks; single-ended ignores the inverted lines
  task automatic t_diff();
    flt = 1'b1;
    steps(4, 1'b0);
    chk("pair hold", 32'h0000_0000, count);
    flt = 1'b0;
    steps(2, 1'b0);
    chk("pair valid", 32'h0000_0002, count);
    diff_en = 1'b0;
    flt = 1'b1;
    steps(2, 1'b0);
    chk("single ended", 32'h0000_0004, count);
    flt = 1'b0;
    $display("test diff done");
  endtask : t_diff

  task automatic t_modes();
    diff_en = 1'b0;
    for (int i = 0; i < 3; i++) begin
      mode = qec_eval_t'(i);
      hit(2, n);
      steps(8, 1'b0);
      chk("mode count", 32'h0000_0008 >> i, count);
    end
    steps(4, 1'b1);
    chk("x1 down", 32'h0000_0001, count);
    $display("test modes done");
  endtask : t_modes

  task automatic t_aux();
    mode = QEC_EVAL_X4;
    wide_en = 1'b1;
    hit(2, n);
    steps(1, 1'b1);
    chk("wide wrap", 32'hffff_ffff, count);
    steps(1, 1'b0);
    hit(1, n);
    chk("set", 32'h1234_5678, count);
    chk("set strobes", 32'h0000_0000, n);
    hit(3, n);
    chk("latch", 32'h1234_5678, al);
    chk("latch strobes", 32'h0000_0001, n);
    wide_en = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk("narrow", 32'h0000_5678, count);
    zl_en = 1'b1;
    hit(0, n);
    chk("zero latch", 32'h0000_5678, zl);
    chk("zero strobes", 32'h0000_0001, n);
    $display("test aux done");
  endtask : t_aux

  task automatic t_pulse();
    pm = 1'b1;
    mode = QEC_EVAL_PULSE;
    hit(2, n);
    steps(6, 1'b0);
    chk("pulse up", 32'h0000_0003, count);
    steps(6, 1'b1);
    chk("pulse down", 32'h0000_0000, count);
    chk("pulse dir", 32'h0000_0001, {31'h0000_0000, dir});
    $display("test pulse done");
  endtask : t_pulse

  // Mid-run reset clears the latches; B high at release is no pulse
  task automatic t_reset();
    rstn_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk("reset aux latch", 32'h0000_0000, al);
    chk("reset zero latch", 32'h0000_0000, zl);
    rstn_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk("reset count", 32'h0000_0000, count);
    chk("reset dir", 32'h0000_0000, {31'h0000_0000, dir});
    $display("test reset done");
  endtask : t_reset

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  initial begin
    {rstn_i, step, dn, pm, idx, flt, diff_en, wide_en, zl_en, a_lat, a_clr, a_set} = 12'h000;
    mode = QEC_EVAL_X4;
    preset = 32'h1234_5678;
    repeat (20) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    t_quad();
    t_diff();
    t_modes();
    t_aux();
    t_pulse();
    t_reset();
    final_report();
  end

  initial begin
    repeat (100000) @(posedge mclk_i);
    err_count++;
    final_report();
  end
endmodule : tb_qec_top
